// File: rtl/gpp_port.sv
// One bank of general purpose port pins with its register port,
// input synchroniser and peripheral override logic.
// Assumes the pad ring resolves each pin from out, enable and pull-up,
// and that peripherals deliver their override requests on core_clk_in.
//
// How it works
// - output latch, direction, input register locations.
// - writing one to input register toggles latch.
// - single bit changes leave other pins alone.
// - global pull-up disable kills every pull-up without a pull-up override.
// - direction drives; input plus one means pull-up.
// - pin level readable in both directions.
// - latch plus two flops synchronise the pin level.
// - latch transparent while the clock is high.
// - alternate functions leave other pins unaffected.
// - serial slave forces its data input pin, unless the transmitter, which shares that pin, is enabled.
// - forced input pin keeps pull-up from latch.
// - enabled transmitter forces its pin to output.
// - slave select forced input, active when low.
// - clock output fuse drives pin, even in reset.
// - two-wire pin open drain, spikes filtered.
// - second serial master forces its input pin.
// - every pin feeds a pin change source.
module gpp_port #(
    parameter int WIDTH = gpp_pkg::PORT_W,
    parameter int DIVIDED_CLOCK_OUTPUT_PIN = gpp_pkg::PIN_DIVIDED_CLOCK_OUTPUT,
    parameter int SS_PIN = gpp_pkg::PIN_SS,
    parameter int MOSI_PIN = gpp_pkg::PIN_MOSI,
    parameter int TX_PIN = gpp_pkg::PIN_TX,
    parameter int TWI_PIN = gpp_pkg::PIN_TWI,
    parameter int MISO1_PIN = gpp_pkg::PIN_MISO1
) (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic rst_in,
    // Register port
    input wire logic [gpp_pkg::ADDR_W-1:0] addr_in,
    input wire logic [WIDTH-1:0] wr_data_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [WIDTH-1:0] rd_data_out,
    // Pins
    input wire logic [WIDTH-1:0] pin_level_in,
    output logic [WIDTH-1:0] pin_out_out,
    output logic [WIDTH-1:0] pin_oe_out,
    output logic [WIDTH-1:0] pin_pullup_out,
    // Generic per-pin overrides
    input wire logic [WIDTH-1:0] pullup_override_enable_in,
    input wire logic [WIDTH-1:0] pullup_override_value_in,
    input wire logic [WIDTH-1:0] direction_override_enable_in,
    input wire logic [WIDTH-1:0] direction_override_value_in,
    input wire logic [WIDTH-1:0] output_override_enable_in,
    input wire logic [WIDTH-1:0] output_override_value_in,
    // Peripheral enables
    input wire logic spi0_slave_enable_in,
    input wire logic spi1_master_enable_in,
    input wire logic serial1_tx_enable_in,
    input wire logic serial1_tx_data_in,
    input wire logic two_wire_enable_in,
    input wire logic two_wire_drive_low_in,
    input wire logic clock_output_fuse_in,
    input wire logic divided_clock_in,
    // Status towards peripherals
    output logic [WIDTH-1:0] pin_change_source_out,
    output logic spi0_select_active_out,
    output logic two_wire_data_filtered_out
);
    import gpp_pkg::*;

    // ****************************************************
    // Software visible registers
    // ****************************************************
    logic [WIDTH-1:0] port_output_latch_r;
    logic [WIDTH-1:0] port_direction_register_r;
    logic global_pullup_disable_r;
    logic [WIDTH-1:0] latch_out_nxt;
    logic [WIDTH-1:0] dir_nxt;

    logic wr_input;
    logic wr_dir;
    logic wr_out;
    assign wr_input = wr_in && (addr_in == OFS_INPUT);
    assign wr_dir = wr_in && (addr_in == OFS_DIR);
    assign wr_out = wr_in && (addr_in == OFS_OUT);

    always_comb begin
        latch_out_nxt = port_output_latch_r;
        if (wr_out) begin
            latch_out_nxt = wr_data_in;
        end else if (wr_in && addr_in == OFS_OUT_SET) begin
            latch_out_nxt = port_output_latch_r | wr_data_in;
        end else if (wr_in && addr_in == OFS_OUT_CLR) begin
            latch_out_nxt = port_output_latch_r & ~wr_data_in;
        end else if (wr_input) begin
            // Toggle ignores the direction bit, so an input pin flips its pull-up.
            latch_out_nxt = port_output_latch_r ^ wr_data_in;
        end
    end

    always_comb begin
        dir_nxt = port_direction_register_r;
        if (wr_dir) begin
            dir_nxt = wr_data_in;
        end else if (wr_in && addr_in == OFS_DIR_SET) begin
            dir_nxt = port_direction_register_r | wr_data_in;
        end else if (wr_in && addr_in == OFS_DIR_CLR) begin
            dir_nxt = port_direction_register_r & ~wr_data_in;
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            port_output_latch_r <= '0;
        end else begin
            port_output_latch_r <= latch_out_nxt;
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            port_direction_register_r <= '0;
        end else begin
            port_direction_register_r <= dir_nxt;
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            global_pullup_disable_r <= RST_PUD;
        end else if (wr_in && addr_in == OFS_CTRL) begin
            global_pullup_disable_r <= wr_data_in[CTRL_PUD_BIT];
        end
    end

    // ****************************************************
    // Input synchroniser
    // ****************************************************
    // The half-cycle stage stands for a latch open while the clock is high:
    // it holds the value seen at the falling edge. Trades latency for safety.
    logic [WIDTH-1:0] in_latch_r;
    logic [WIDTH-1:0] in_s2_r;
    logic [WIDTH-1:0] in_s3_r;
    logic [WIDTH-1:0] in_acc_r;
    logic [WIDTH-1:0] in_acc_nxt;

    always_ff @(negedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            in_latch_r <= '0;
        end else begin
            in_latch_r <= pin_level_in;
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            in_s2_r <= '0;
            in_s3_r <= '0;
        end else begin
            in_s2_r <= in_latch_r;
            in_s3_r <= in_s2_r;
        end
    end

    // A change is accepted only once the two later stages agree.
    assign in_acc_nxt = (~(in_s2_r ^ in_s3_r) & in_s2_r) | ((in_s2_r ^ in_s3_r) & in_acc_r);

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            in_acc_r <= '0;
        end else begin
            in_acc_r <= in_acc_nxt;
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            pin_change_source_out <= '0;
        end else begin
            pin_change_source_out <= in_acc_nxt ^ in_acc_r;
        end
    end

    // ****************************************************
    // Read port
    // ****************************************************
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            rd_data_out <= '0;
        end else if (rd_in) begin
            case (addr_in)
                OFS_INPUT: rd_data_out <= in_acc_r;
                OFS_DIR: rd_data_out <= port_direction_register_r;
                OFS_OUT: rd_data_out <= port_output_latch_r;
                OFS_CTRL: rd_data_out <= WIDTH'(global_pullup_disable_r);
                default: rd_data_out <= '0;
            endcase
        end else begin
            rd_data_out <= '0;
        end
    end

    // ****************************************************
    // Peripheral status
    // ****************************************************
    logic [SPIKE_CNT_W-1:0] spike_cnt_r;

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            spi0_select_active_out <= RST_BIT;
        end else begin
            spi0_select_active_out <= spi0_slave_enable_in & ~in_acc_r[SS_PIN];
        end
    end

    // A new level must stand SPIKE_CYC cycles before it passes the filter.
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            spike_cnt_r <= '0;
            two_wire_data_filtered_out <= RST_BIT;
        end else if (in_acc_r[TWI_PIN] == two_wire_data_filtered_out) begin
            spike_cnt_r <= '0;
        end else if (spike_cnt_r == SPIKE_CNT_W'(SPIKE_CYC - 1)) begin
            spike_cnt_r <= '0;
            two_wire_data_filtered_out <= in_acc_r[TWI_PIN];
        end else begin
            spike_cnt_r <= spike_cnt_r + SPIKE_CNT_W'(1);
        end
    end

    // ****************************************************
    // Per-pin drive stage
    // ****************************************************
    // Each pin resolves its own overrides, so a peripheral on one pin
    // never disturbs the others. Software must still set the direction
    // for timer outputs; no timer override exists here.
    for (genvar i = 0; i < WIDTH; i++) begin : g_pin
        logic dir_e;
        logic out_e;
        logic pu_e;
        logic drv_r;
        logic oe_r;
        logic pu_r;

        always_comb begin
            dir_e = direction_override_enable_in[i] ? direction_override_value_in[i]
                                                    : port_direction_register_r[i];
            out_e = output_override_enable_in[i] ? output_override_value_in[i]
                                                 : port_output_latch_r[i];
            pu_e = ~dir_e & port_output_latch_r[i] & ~global_pullup_disable_r;
            if (pullup_override_enable_in[i]) begin
                pu_e = pullup_override_value_in[i];
            end
            if ((spi0_slave_enable_in && (i == MOSI_PIN || i == SS_PIN)) ||
                (spi1_master_enable_in && i == MISO1_PIN)) begin
                dir_e = 1'b0;
                pu_e = port_output_latch_r[i] & ~global_pullup_disable_r;
            end
            if (serial1_tx_enable_in && i == TX_PIN) begin
                dir_e = 1'b1;
                out_e = serial1_tx_data_in;
                pu_e = 1'b0;
            end
            if (two_wire_enable_in && i == TWI_PIN) begin
                dir_e = two_wire_drive_low_in;
                out_e = 1'b0;
                pu_e = port_output_latch_r[i] & ~global_pullup_disable_r;
            end
        end

        if (i == DIVIDED_CLOCK_OUTPUT_PIN) begin : g_divided_clock_output
            // No reset here: the divided clock must keep running during reset.
            always_ff @(posedge core_clk_in) begin
                drv_r <= clock_output_fuse_in ? divided_clock_in : out_e;
                oe_r <= clock_output_fuse_in | dir_e;
                pu_r <= ~clock_output_fuse_in & pu_e;
            end
        end else begin : g_gen
            always_ff @(posedge core_clk_in or posedge rst_in) begin
                if (rst_in) begin
                    drv_r <= RST_BIT;
                    oe_r <= RST_BIT;
                    pu_r <= RST_BIT;
                end else begin
                    drv_r <= out_e;
                    oe_r <= dir_e;
                    pu_r <= pu_e & ~(global_pullup_disable_r & ~pullup_override_enable_in[i]);
                end
            end
        end

        assign pin_out_out[i] = drv_r;
        assign pin_oe_out[i] = oe_r;
        assign pin_pullup_out[i] = pu_r;
    end

    // ****************************************************
    // Checks
    // ****************************************************
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (rst_in);

    logic no_periph;
    assign no_periph = !spi0_slave_enable_in && !spi1_master_enable_in &&
                       !serial1_tx_enable_in && !two_wire_enable_in &&
                       !(|direction_override_enable_in) && !(|output_override_enable_in);

    a_toggle_latch: assert property (
        wr_input |=> port_output_latch_r == ($past(port_output_latch_r) ^ $past(wr_data_in)))
        else $error("input register write did not toggle the output latch");

    a_dir_bitset: assert property (
        wr_in && addr_in == OFS_DIR_SET
        |=> port_direction_register_r == ($past(port_direction_register_r) | $past(wr_data_in)))
        else $error("direction bit set disturbed other pins");

    a_read_sync: assert property (
        rd_in && addr_in == OFS_INPUT |=> rd_data_out == $past(in_acc_r))
        else $error("input read did not return the synchronised level");

    a_pullup_off: assert property (
        global_pullup_disable_r && !(|pullup_override_enable_in) |=> pin_pullup_out == '0)
        else $error("pull-up active while globally disabled");

    a_dir_drive: assert property (
        no_periph && !clock_output_fuse_in
        |=> pin_oe_out == $past(port_direction_register_r))
        else $error("pin enable does not follow the direction register");

    a_tx_forced: assert property (
        serial1_tx_enable_in |=> pin_oe_out[TX_PIN] && pin_out_out[TX_PIN] == $past(serial1_tx_data_in))
        else $error("transmit pin not forced to output");

    a_mosi_input: assert property (
        spi0_slave_enable_in && !serial1_tx_enable_in |=> !pin_oe_out[MOSI_PIN] && !pin_oe_out[SS_PIN])
        else $error("serial slave input pin is driven");

    a_twi_open: assert property (
        two_wire_enable_in |=> !pin_out_out[TWI_PIN] && pin_oe_out[TWI_PIN] == $past(two_wire_drive_low_in))
        else $error("two-wire pin is not open drain");

    a_pin_change: assert property (
        in_acc_r != $past(in_acc_r) |-> pin_change_source_out == (in_acc_r ^ $past(in_acc_r)))
        else $error("pin change pulse missing or wrong");

    a_sync_agree: assert property (
        in_s2_r != in_s3_r
        |=> (($past(in_s2_r) ^ $past(in_s3_r)) & (in_acc_r ^ $past(in_acc_r))) == '0)
        else $error("input accepted before synchroniser stages agreed");

endmodule // gpp_port

// File: rtl/gpp_pkg.sv
// Constants shared by the general purpose port block: register map,
// control bit positions, reset values and timing figures.
// Assumes a single 50 MHz system clock and a plain register port.
package gpp_pkg;

    // ****************************************************
    // Register bus
    // ****************************************************
    localparam int ADDR_W = 4;

    localparam logic [ADDR_W-1:0] OFS_INPUT = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_DIR = 4'h1;
    localparam logic [ADDR_W-1:0] OFS_OUT = 4'h2;
    localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h3;
    localparam logic [ADDR_W-1:0] OFS_DIR_SET = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_DIR_CLR = 4'h5;
    localparam logic [ADDR_W-1:0] OFS_OUT_SET = 4'h6;
    localparam logic [ADDR_W-1:0] OFS_OUT_CLR = 4'h7;

    // ****************************************************
    // Control register layout and reset values
    // ****************************************************
    localparam int CTRL_PUD_BIT = 0;
    localparam logic RST_PUD = 1'b0;
    localparam logic RST_BIT = 1'b0;

    // ****************************************************
    // Timing
    // ****************************************************
    localparam int CLK_PERIOD_NS = 20;
    localparam int SPIKE_NS = 50;
    // Least time, so round up to whole cycles.
    localparam int SPIKE_CYC = (SPIKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SPIKE_CNT_W = 4;

    // ****************************************************
    // Default pin placement of peripheral functions
    // ****************************************************
    localparam int PORT_W = 8;
    localparam int PIN_DIVIDED_CLOCK_OUTPUT = 0;
    localparam int PIN_SS = 2;
    localparam int PIN_MOSI = 3;
    localparam int PIN_TX = 3;
    localparam int PIN_TWI = 4;
    localparam int PIN_MISO1 = 5;

endpackage : gpp_pkg

// File: bench/gpp_pin_model.sv
// External circuit around one port bank: resolves each pin level.
// Assumes the bench drives ext_en_in/ext_val_in in the design's place.
module gpp_pin_model #(
    parameter int W = 8
) (
    // Clock
    input wire logic clk_in,
    // Design side
    input wire logic [W-1:0] out_in,
    input wire logic [W-1:0] oe_in,
    input wire logic [W-1:0] pullup_in,
    // Outside drivers
    input wire logic [W-1:0] ext_en_in,
    input wire logic [W-1:0] ext_val_in,
    // Resolved level
    output logic [W-1:0] level_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****
    // Resolution
    // ****
    logic [W-1:0] float_r = '0;
    // A floating pin wanders every cycle, so a stale level never passes for data.
    always @(posedge clk_in) float_r <= ~float_r;
    // The design's driver wins; an open-drain release leaves the outside level.
    assign level_out = (oe_in & out_in) | (~oe_in & ext_en_in & ext_val_in)
        | (~oe_in & ~ext_en_in & (pullup_in | float_r));
endmodule // gpp_pin_model

// File: bench/gpp_port_bench.sv
// Self-checking bench for the general purpose port bank.
// Assumes the pin model closes the loop from pin outputs to pin levels.
module gpp_port_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import gpp_pkg::*;
    // ****
    // Stimulus and monitors
    // ****
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [ADDR_W-1:0] addr = 4'h0;
    logic [7:0] wdat = 8'h00, rdat, lvl, pout, poe, ppu, pcs, pc_seen = 8'h00;
    logic [7:0] ext_val = 8'h00, ext_en = 8'hFF;
    logic [7:0] pu_en = 8'h00, pu_val = 8'h00, dd_en = 8'h00, dd_val = 8'h00;
    logic [7:0] oo_en = 8'h00, oo_val = 8'h00;
    logic wr = 1'b0, rd = 1'b0, spi0s = 1'b0, spi1m = 1'b0, txe = 1'b0, txd = 1'b0;
    logic twe = 1'b0, twl = 1'b0, fuse = 1'b0, dclk = 1'b0, sel, twf;
    logic pc_clr = 1'b0, tw_ok = 1'b1;
    int fails = 0, checks = 0, cyc = 0;

    gpp_port i_gpp_port (
        .core_clk_in(clk), .rst_in(rst), .addr_in(addr), .wr_data_in(wdat),
        .wr_in(wr), .rd_in(rd), .rd_data_out(rdat), .pin_level_in(lvl),
        .pin_out_out(pout), .pin_oe_out(poe), .pin_pullup_out(ppu),
        .pullup_override_enable_in(pu_en), .pullup_override_value_in(pu_val),
        .direction_override_enable_in(dd_en), .direction_override_value_in(dd_val),
        .output_override_enable_in(oo_en), .output_override_value_in(oo_val),
        .spi0_slave_enable_in(spi0s), .spi1_master_enable_in(spi1m),
        .serial1_tx_enable_in(txe), .serial1_tx_data_in(txd),
        .two_wire_enable_in(twe), .two_wire_drive_low_in(twl),
        .clock_output_fuse_in(fuse), .divided_clock_in(dclk),
        .pin_change_source_out(pcs), .spi0_select_active_out(sel),
        .two_wire_data_filtered_out(twf)
    );
    gpp_pin_model i_gpp_pin_model (
        .clk_in(clk), .out_in(pout), .oe_in(poe), .pullup_in(ppu),
        .ext_en_in(ext_en), .ext_val_in(ext_val), .level_out(lvl)
    );

    always #10 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        pc_seen <= pc_clr ? 8'h00 : (pc_seen | pcs);
        tw_ok <= pc_clr ? 1'b1 : (tw_ok & twf);
        if (cyc == 2000) begin
            fails++;
            summarize();
        end
    end
    // ****
    // Tasks
    // ****
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
            fails++;
        end
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdat <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input string nm, input logic [ADDR_W-1:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(nm, e, rdat);
    endtask
    task automatic pins(input logic [7:0] e_oe, input logic [7:0] e_pu);
        chk("oe", e_oe, poe);
        chk("pullup", e_pu, ppu);
    endtask
    task automatic summarize;
        if (fails == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // ****
    // Sequence
    // ****
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rd_chk("dir", OFS_DIR, 8'h00);
        rd_chk("out", OFS_OUT, 8'h00);
        rd_chk("ctrl", OFS_CTRL, 8'h00);
        rd_chk("unmapped", 4'h8, 8'h00);
        rd_chk("set_only", OFS_DIR_SET, 8'h00);
        // Pins 7 and 5 pass through output low on their way to output high.
        wr_reg(OFS_DIR, 8'hF0);
        wr_reg(OFS_OUT, 8'hA5);
        rd_chk("dir", OFS_DIR, 8'hF0);
        rd_chk("out", OFS_OUT, 8'hA5);
        wait_cyc(5);
        pins(8'hF0, 8'h05);
        chk("drive", 8'hA0, pout & poe);
        rd_chk("in", OFS_INPUT, 8'hA0);
        wr_reg(OFS_INPUT, 8'h81);
        rd_chk("toggle", OFS_OUT, 8'h24);
        // Pin 0 leaves pull-up input for output low by way of tri-state.
        wr_reg(OFS_DIR_SET, 8'h01);
        wr_reg(OFS_DIR_CLR, 8'h80);
        wr_reg(OFS_OUT_SET, 8'h02);
        wr_reg(OFS_OUT_CLR, 8'h20);
        rd_chk("dir", OFS_DIR, 8'h71);
        rd_chk("out", OFS_OUT, 8'h06);
        wait_cyc(2);
        pins(8'h71, 8'h06);
        // Let pins 1 and 2 float so only their pull-ups set the level.
        @(posedge clk);
        ext_en <= 8'hF9;
        wait_cyc(5);
        rd_chk("pulled", OFS_INPUT, 8'h06);
        @(posedge clk);
        ext_en <= 8'hFF;
        wr_reg(OFS_CTRL, 8'h01);
        wait_cyc(2);
        pins(8'h71, 8'h00);
        rd_chk("ctrl", OFS_CTRL, 8'h01);
        wr_reg(OFS_CTRL, 8'h00);
        @(posedge clk);
        pc_clr <= 1'b1;
        @(posedge clk);
        pc_clr <= 1'b0;
        ext_val <= 8'h8C;
        rd_chk("in_old", OFS_INPUT, 8'h00);
        wait_cyc(5);
        rd_chk("in_new", OFS_INPUT, 8'h8C);
        chk("pin_change", 8'h8C, pc_seen);
        wr_reg(OFS_DIR, 8'hFF);
        spi0s <= 1'b1;
        wait_cyc(2);
        pins(8'hF3, 8'h04);
        chk("select", 8'h00, {7'h00, sel});
        @(posedge clk);
        ext_val <= 8'h88;
        wait_cyc(6);
        chk("select", 8'h01, {7'h00, sel});
        @(posedge clk);
        spi1m <= 1'b1;
        txe <= 1'b1;
        txd <= 1'b1;
        wait_cyc(2);
        pins(8'hDB, 8'h04);
        chk("tx", 8'h08, pout & 8'h08);
        @(posedge clk);
        {spi0s, spi1m, txe} <= 3'h0;
        dd_en <= 8'h80;
        oo_en <= 8'h40;
        oo_val <= 8'h40;
        pu_en <= 8'h01;
        pu_val <= 8'h01;
        wait_cyc(2);
        pins(8'h7F, 8'h01);
        chk("ovr_out", 8'h46, pout & 8'h7F);
        @(posedge clk);
        {dd_en, oo_en, pu_en} <= 24'h000000;
        wr_reg(OFS_DIR, 8'h00);
        twe <= 1'b1;
        twl <= 1'b1;
        wait_cyc(2);
        chk("twi_low", 8'h10, poe & ~pout & 8'h10);
        @(posedge clk);
        twl <= 1'b0;
        ext_val <= 8'h98;
        wait_cyc(10);
        chk("twi_rel", 8'h00, poe & 8'h10);
        chk("twi_hi", 8'h01, {7'h00, twf});
        @(posedge clk);
        pc_clr <= 1'b1;
        @(posedge clk);
        pc_clr <= 1'b0;
        ext_val <= 8'h88;
        // A 40 ns low pulse gets through the synchroniser but not the filter.
        @(posedge clk);
        @(posedge clk);
        ext_val <= 8'h98;
        wait_cyc(10);
        chk("spike", 8'h01, {7'h00, tw_ok});
        @(posedge clk);
        ext_val <= 8'h88;
        wait_cyc(10);
        chk("twi_lo", 8'h00, {7'h00, twf});
        @(posedge clk);
        twe <= 1'b0;
        fuse <= 1'b1;
        dclk <= 1'b1;
        rst <= 1'b1;
        wait_cyc(3);
        chk("divided_clock_output_rst", 8'h01, poe);
        chk("divided_clock_output_hi", 8'h01, pout & 8'h01);
        @(posedge clk);
        dclk <= 1'b0;
        wait_cyc(2);
        chk("divided_clock_output_lo", 8'h00, pout & 8'h01);
        @(posedge clk);
        rst <= 1'b0;
        wait_cyc(2);
        chk("divided_clock_output_run", 8'h01, poe & 8'h01);
        summarize();
    end
endmodule // gpp_port_bench
